// *** pll_ctl_cfg.svh ***
// constants for the synthesizer and bus-clock control block
// assumes byte registers reached over a plain strobe port
`ifndef PLL_CTL_CFG_SVH
`define PLL_CTL_CFG_SVH

// ============================================================
// register offsets
`define PLL_CONTROL_OFFSET 8'h2e
`define SYNTH_MULTIPLIER_OFFSET 8'h2f

// ============================================================
// pll_control field positions
`define POWER_ON_BIT 7
`define BUS_SRC_BIT 6
`define SELF_BW_BIT 5
`define HIGH_BW_BIT 4
`define FILTER_TEST_BIT 3
`define MODULE_SRC_BIT 2
`define LOCK_BIT 1
`define WAIT_SLOW_BIT 0

// ============================================================
// synth_multiplier field positions
`define TAPS_MSB 7
`define TAPS_LSB 6
`define MODULUS_MSB 5
`define MODULUS_LSB 0

// ============================================================
// reset values
`define PLL_CONTROL_RESET 8'ha8
`define SYNTH_MULTIPLIER_RESET 8'h0b
`define TAPS_RESET 2'h0
`define MODULUS_RESET 6'h0b
`define IDLE_MODULUS 6'h00

`endif

// *** pll_ctl_pkg.sv ***
// types shared by the synthesizer control block
// assumes the constants header is included by the design file
package pll_ctl_pkg;

  // ============================================================
  // power state of the synthesizer loop
  typedef enum logic [1:0] {
    LOOP_OFF = 2'b00,
    LOOP_RUN = 2'b01,
    LOOP_IDLE = 2'b10
  } loop_state_type;

endpackage

// *** pll_clock_synth_control.sv ***
// control logic for the frequency synthesizer and bus-clock select
// assumes the analog loop, its lock and near-target detectors and the
// glitch-free clock multiplexers sit outside and follow the selects here
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

module pll_clock_synth_control #(
  parameter int NUM_RX = 3
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic test_mode_i,
  input wire logic lock_raw_i,
  input wire logic near_target_raw_i,
  input wire logic wait_entry_i,
  input wire logic irq_i,
  input wire logic [NUM_RX-1:0] receiver_active_flag_i,
  input wire logic [NUM_RX-1:0] receiver_enable_bit_i,
  output logic synth_run_o,
  output logic synth_idle_o,
  output logic bus_src_vco_o,
  output logic module_src_quad_o,
  output logic high_bw_drive_o,
  output logic low_bw_drive_o,
  output logic filter_test_o,
  output logic [1:0] prescale_taps_o,
  output logic [5:0] loop_modulus_o
);

  // ============================================================
  // elaboration checks
  if (NUM_RX < 1 || NUM_RX > 8) begin : g_bad_rx
    $error("NUM_RX must lie between 1 and 8");
  end

  // ============================================================
  // state
  logic [2:0] lock_sync;
  logic [2:0] near_sync;
  logic lock_flag;
  logic near_flag;
  logic pll_power_on;
  logic bus_clock_source_sel;
  logic bandwidth_self_select;
  logic bandwidth_high_sel;
  logic loop_filter_test;
  logic module_clock_sel;
  logic wait_slowdown_enable;
  logic idle;
  logic [1:0] prescale_taps;
  logic [5:0] loop_modulus;
  pll_ctl_pkg::loop_state_type loop_state;
  // packed control default, split into its bits at reset
  localparam logic [7:0] CTL_RST = `PLL_CONTROL_RESET;

  // ============================================================
  // pin synchronisers: three stages, a change counts once 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lock_sync <= 3'h0;
      near_sync <= 3'h0;
    end else begin
      lock_sync <= {lock_sync[1:0], lock_raw_i};
      near_sync <= {near_sync[1:0], near_target_raw_i};
    end
  end

  // filtered levels hold their value while stages 2 and 3 disagree
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lock_flag <= 1'b0;
      near_flag <= 1'b0;
    end else begin
      if (lock_sync[1] == lock_sync[2]) begin
        lock_flag <= lock_sync[2];
      end
      if (near_sync[1] == near_sync[2]) begin
        near_flag <= near_sync[2];
      end
    end
  end

  // ============================================================
  // register decode
  wire ctl_hit = (addr_i == `PLL_CONTROL_OFFSET);
  wire mul_hit = (addr_i == `SYNTH_MULTIPLIER_OFFSET);
  wire ctl_wr = wr_en_i && ctl_hit;
  wire mul_wr = wr_en_i && mul_hit;

  // ============================================================
  // wake and wait events
  // a disabled receiver is masked so its activity flag cannot wake us
  wire [NUM_RX-1:0] rx_wake = receiver_active_flag_i & receiver_enable_bit_i;
  wire wake = irq_i || (|rx_wake);
  // the cpu raises wait_entry_i only after it has stacked its registers
  wire wait_go = wait_entry_i && wait_slowdown_enable && !wake;

  // ============================================================
  // interlocked next values for power and bus source
  // the select is judged against the power bit already stored, so
  // enabling and switching over always take two separate writes
  wire wr_bus_sel = wr_data_i[`BUS_SRC_BIT] && pll_power_on;
  wire next_bus_clock_source_sel = wait_go ? 1'b0 :
    (ctl_wr ? wr_bus_sel : bus_clock_source_sel);
  // power stays on while the bus is, or is about to be, fed by it
  wire next_pll_power_on = ctl_wr ?
    (wr_data_i[`POWER_ON_BIT] || bus_clock_source_sel || wr_bus_sel) :
    pll_power_on;

  // ============================================================
  // bandwidth control
  wire next_self = ctl_wr ? wr_data_i[`SELF_BW_BIT] : bandwidth_self_select;
  // in self mode the bit becomes status: high until near target
  wire auto_bw = pll_power_on && !idle && !near_flag;
  wire next_bandwidth_high_sel = bandwidth_self_select ? auto_bw :
    (ctl_wr ? wr_data_i[`HIGH_BW_BIT] : bandwidth_high_sel);
  // filter test is forced while in self mode, writable only in test mode
  wire next_loop_filter_test = next_self ? 1'b1 :
    ((ctl_wr && test_mode_i) ? wr_data_i[`FILTER_TEST_BIT] : loop_filter_test);

  // ============================================================
  // idle handling: wake has priority over a coincident wait entry
  wire next_idle = wake ? 1'b0 : (wait_go ? 1'b1 : idle);

  // ============================================================
  // control register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pll_power_on <= CTL_RST[`POWER_ON_BIT];
      bus_clock_source_sel <= CTL_RST[`BUS_SRC_BIT];
      bandwidth_self_select <= CTL_RST[`SELF_BW_BIT];
      bandwidth_high_sel <= CTL_RST[`HIGH_BW_BIT];
      loop_filter_test <= CTL_RST[`FILTER_TEST_BIT];
      module_clock_sel <= CTL_RST[`MODULE_SRC_BIT];
      wait_slowdown_enable <= CTL_RST[`WAIT_SLOW_BIT];
    end else begin
      pll_power_on <= next_pll_power_on;
      bus_clock_source_sel <= next_bus_clock_source_sel;
      bandwidth_self_select <= next_self;
      bandwidth_high_sel <= next_bandwidth_high_sel;
      loop_filter_test <= next_loop_filter_test;
      if (ctl_wr) begin
        module_clock_sel <= wr_data_i[`MODULE_SRC_BIT];
        wait_slowdown_enable <= wr_data_i[`WAIT_SLOW_BIT];
      end
    end
  end

  // idle state; a reset always leaves the loop at its programmed rate
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      idle <= 1'b0;
    end else begin
      idle <= next_idle;
    end
  end

  // ============================================================
  // multiplier register: factor is 2*(modulus+1)*2^taps
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prescale_taps <= `TAPS_RESET;
      loop_modulus <= `MODULUS_RESET;
    end else if (mul_wr) begin
      prescale_taps <= wr_data_i[`TAPS_MSB:`TAPS_LSB];
      loop_modulus <= wr_data_i[`MODULUS_MSB:`MODULUS_LSB];
    end
  end

  // ============================================================
  // loop state, derived for outputs
  wire lock_view = lock_flag;
  always_comb begin
    loop_state = pll_ctl_pkg::LOOP_OFF;
    if (pll_power_on) begin
      loop_state = idle ? pll_ctl_pkg::LOOP_IDLE : pll_ctl_pkg::LOOP_RUN;
    end
  end

  // ============================================================
  // read data; lock bit comes from status, writes never touch it
  wire [7:0] ctl_view = {pll_power_on, bus_clock_source_sel, bandwidth_self_select,
    bandwidth_high_sel, loop_filter_test, module_clock_sel, lock_view,
    wait_slowdown_enable};
  wire [7:0] mul_view = {prescale_taps, loop_modulus};
  wire [7:0] next_rd_data = !rd_en_i ? 8'h00 :
    (ctl_hit ? ctl_view : (mul_hit ? mul_view : 8'h00));

  // ============================================================
  // registered outputs
  // the bus select only steers an external glitch-free mux, which
  // hands over within 1.5 crystal plus 1.5 oscillator cycles
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
      synth_run_o <= 1'b0;
      synth_idle_o <= 1'b0;
      bus_src_vco_o <= 1'b0;
      module_src_quad_o <= 1'b0;
      high_bw_drive_o <= 1'b0;
      low_bw_drive_o <= 1'b0;
      filter_test_o <= 1'b0;
      prescale_taps_o <= `TAPS_RESET;
      loop_modulus_o <= `MODULUS_RESET;
    end else begin
      rd_data_o <= next_rd_data;
      synth_run_o <= (loop_state != pll_ctl_pkg::LOOP_OFF);
      synth_idle_o <= (loop_state == pll_ctl_pkg::LOOP_IDLE);
      bus_src_vco_o <= bus_clock_source_sel;
      module_src_quad_o <= module_clock_sel;
      high_bw_drive_o <= bandwidth_high_sel;
      low_bw_drive_o <= 1'b1;
      filter_test_o <= loop_filter_test;
      prescale_taps_o <= prescale_taps;
      loop_modulus_o <= idle ? `IDLE_MODULUS : loop_modulus;
    end
  end

  // ============================================================
  // assertions
  // interlock and bandwidth properties watch the stored control bits
  a_power_held_busy: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    bus_clock_source_sel |=> pll_power_on)
    else $error("synthesizer powered off while feeding the bus");

  a_select_needs_power: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ctl_wr && !pll_power_on) |=> !bus_clock_source_sel)
    else $error("bus select taken while synthesizer off");

  a_bus_mux_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $changed(bus_clock_source_sel) |=> (bus_src_vco_o == $past(bus_clock_source_sel)))
    else $error("bus source output did not follow select");

  a_power_no_switch: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(pll_power_on) && !$past(bus_clock_source_sel) |-> !bus_clock_source_sel)
    else $error("power-on switched the bus clock");

  a_manual_bw_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ctl_wr && !bandwidth_self_select) |=>
    (bandwidth_high_sel == $past(wr_data_i[`HIGH_BW_BIT])))
    else $error("manual bandwidth write lost");

  a_auto_bw_status: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (bandwidth_self_select && pll_power_on && !idle && !near_flag) |=> bandwidth_high_sel)
    else $error("self mode did not hold high bandwidth at start-up");

  a_self_bw_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (bandwidth_self_select && (near_flag || !pll_power_on)) |=> !bandwidth_high_sel)
    else $error("self mode kept high bandwidth near target");

  a_filter_forced: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    bandwidth_self_select |-> loop_filter_test)
    else $error("filter test clear in self mode");

  a_filter_test_only: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (!test_mode_i && !next_self) |=> $stable(loop_filter_test))
    else $error("filter test changed outside test mode");

  a_wait_idles: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wait_go |=> (idle && !bus_clock_source_sel) ##1 (loop_modulus_o == 6'h00 || !idle))
    else $error("wait entry did not idle the synthesizer");

  a_wait_ignored: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wait_entry_i && !wait_slowdown_enable && !idle) |=> !idle)
    else $error("wait entry idled the synthesizer with slowdown off");

  a_wake_resumes: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wake |=> !idle ##1 (loop_modulus_o == $past(loop_modulus)))
    else $error("wake event did not resume programmed rate");

  a_wake_beats_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wait_entry_i && irq_i) |=> !idle)
    else $error("wait entry won over a coincident interrupt");

  a_disabled_rx: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (idle && !irq_i && ((receiver_active_flag_i & receiver_enable_bit_i) == {NUM_RX{1'b0}}))
    |=> idle)
    else $error("idle left without an enabled receiver or interrupt");

  a_lock_read_only: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rd_en_i && ctl_hit) |=> (rd_data_o[`LOCK_BIT] == $past(lock_flag)))
    else $error("lock bit read does not show status");

  a_low_bw_on: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> low_bw_drive_o)
    else $error("low bandwidth driver off");

  a_reset_values: assert property (@(posedge core_clk_i)
    !rstn_i |=> (ctl_view[7:2] == 6'h2a && ctl_view[0] == 1'b0 && mul_view == 8'h0b))
    else $error("reset defaults wrong");

  // ============================================================
  // assertions: status, outputs and register bus
  // each output register except the modulus, the idle output (idle gated by power), the low drive and the read data must mirror its stored bit one edge later
  a_lock_follows: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (lock_sync[1] == lock_sync[2]) |=> (lock_flag == $past(lock_sync[2])))
    else $error("lock flag missed an agreed detector level");

  a_lock_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (lock_sync[1] != lock_sync[2]) |=> $stable(lock_flag))
    else $error("lock flag moved while the stages disagreed");

  a_run_follows: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (synth_run_o == $past(pll_power_on)))
    else $error("run output does not follow the power bit");

  a_idle_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (synth_idle_o == ($past(pll_power_on) && $past(idle))))
    else $error("idle output does not follow the idle state");

  a_bus_src_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (bus_src_vco_o == $past(bus_clock_source_sel)))
    else $error("bus source output stale");

  a_module_src_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (module_src_quad_o == $past(module_clock_sel)))
    else $error("module source output stale");

  a_high_drive_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (high_bw_drive_o == $past(bandwidth_high_sel)))
    else $error("high bandwidth driver does not follow its bit");

  a_filter_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (filter_test_o == $past(loop_filter_test)))
    else $error("filter test output stale");

  a_taps_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i ##1 rstn_i |-> (prescale_taps_o == $past(prescale_taps)))
    else $error("prescale taps output stale");

  a_taps_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    mul_wr |=> (prescale_taps == $past(wr_data_i[`TAPS_MSB:`TAPS_LSB])))
    else $error("prescale taps write lost");

  a_modulus_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    mul_wr |=> (loop_modulus == $past(wr_data_i[`MODULUS_MSB:`MODULUS_LSB])))
    else $error("loop modulus write lost");

  a_modulus_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !mul_wr |=> $stable(loop_modulus))
    else $error("loop modulus changed without a write");

  a_rd_data_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !rd_en_i |=> (rd_data_o == 8'h00))
    else $error("read data left standing without a read");

  a_unmapped_rd: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rd_en_i && !ctl_hit && !mul_hit) |=> (rd_data_o == 8'h00))
    else $error("unmapped read returned data");

endmodule

// *** pll_clock_synth_control_tb.sv ***
// self-checking bench for the synthesizer and bus-clock control block
// assumes the design and its constants header are compiled before this file
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"

module pll_clock_synth_control_tb;
  // ============================================================
  // stimulus and observed signals
  localparam int SETTLE_CYCLES = 20; // short stand-in for the loop settle time
  localparam logic [7:0] PC = `PLL_CONTROL_OFFSET;
  localparam logic [7:0] SM = `SYNTH_MULTIPLIER_OFFSET;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic test_mode_i = 1'b0;
  logic lock_raw_i = 1'b0;
  logic near_target_raw_i = 1'b1;
  logic wait_entry_i = 1'b0;
  logic irq_i = 1'b0;
  logic [2:0] receiver_active_flag_i = 3'h0;
  logic [2:0] receiver_enable_bit_i = 3'h0;
  logic [7:0] rd_data_o;
  logic synth_run_o, synth_idle_o, bus_src_vco_o, module_src_quad_o;
  logic high_bw_drive_o, low_bw_drive_o, filter_test_o;
  logic [1:0] prescale_taps_o;
  logic [5:0] loop_modulus_o;
  logic [7:0] mult_tab [4] = '{8'h00, 8'h8a, 8'hff, 8'h45};
  int num_errors = 0;
  int check_count = 0;

  // 20 MHz core clock
  always #25 core_clk_i = ~core_clk_i;

  pll_clock_synth_control #(.NUM_RX(3)) i_pll_clock_synth_control (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .test_mode_i(test_mode_i),
    .lock_raw_i(lock_raw_i), .near_target_raw_i(near_target_raw_i),
    .wait_entry_i(wait_entry_i), .irq_i(irq_i),
    .receiver_active_flag_i(receiver_active_flag_i),
    .receiver_enable_bit_i(receiver_enable_bit_i), .synth_run_o(synth_run_o),
    .synth_idle_o(synth_idle_o), .bus_src_vco_o(bus_src_vco_o),
    .module_src_quad_o(module_src_quad_o), .high_bw_drive_o(high_bw_drive_o),
    .low_bw_drive_o(low_bw_drive_o), .filter_test_o(filter_test_o),
    .prescale_taps_o(prescale_taps_o), .loop_modulus_o(loop_modulus_o));

  // ============================================================
  // shared tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // wait n edges, then look just after the last one so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk(name, exp, rd_data_o);
  endtask

  task automatic pulse_wait;
    @(posedge core_clk_i);
    wait_entry_i <= 1'b1;
    @(posedge core_clk_i);
    wait_entry_i <= 1'b0;
    settle(2);
  endtask

  // callers arrive just after an edge, so reset spans exactly four edges
  task automatic do_reset;
    rstn_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    settle(4);
  endtask

  // the unmapped write must leave both registers at their defaults
  task automatic check_defaults;
    wr(8'h2d, 8'hff);
    rd(PC, `PLL_CONTROL_RESET, "pll_control");
    rd(SM, `SYNTH_MULTIPLIER_RESET, "synth_multiplier");
    rd(8'h30, 8'h00, "unmapped read");
    chk("run", 8'h01, synth_run_o);
    chk("bus src", 8'h00, bus_src_vco_o);
    chk("low drive", 8'h01, low_bw_drive_o);
    chk("filter test", 8'h01, filter_test_o);
    chk("taps", `TAPS_RESET, prescale_taps_o);
    chk("modulus", `MODULUS_RESET, loop_modulus_o);
    chk("idle", 8'h00, synth_idle_o);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still ends in the verdict
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    $display("wrong value run length expected end seen timeout");
    give_verdict;
  end

  // ============================================================
  // main sequence
  initial begin
    do_reset;
    check_defaults;
    // lock flag follows the detector and ignores writes
    @(posedge core_clk_i) lock_raw_i <= 1'b1;
    settle(6);
    rd(PC, 8'haa, "lock");
    wr(PC, 8'ha8);
    rd(PC, 8'haa, "lock");
    // automatic bandwidth: high until near target, bit writes ignored
    @(posedge core_clk_i) near_target_raw_i <= 1'b0;
    settle(6);
    wr(PC, 8'ha8);
    rd(PC, 8'hba, "auto bw");
    chk("high drive", 8'h01, high_bw_drive_o);
    @(posedge core_clk_i) near_target_raw_i <= 1'b1;
    settle(6);
    wr(PC, 8'hb8);
    rd(PC, 8'haa, "auto bw");
    chk("high drive", 8'h00, high_bw_drive_o);
    // interlock between power and bus select
    wr(PC, 8'he8);
    rd(PC, 8'hea, "bus on");
    chk("bus src", 8'h01, bus_src_vco_o);
    wr(PC, 8'h68);
    rd(PC, 8'hea, "power kept");
    wr(PC, 8'ha8);
    wr(PC, 8'h28);
    rd(PC, 8'h2a, "power off");
    chk("run", 8'h00, synth_run_o);
    wr(PC, 8'h68);
    rd(PC, 8'h2a, "bus refused");
    chk("bus src", 8'h00, bus_src_vco_o);
    // multiplier fields, rewritten while powered down
    foreach (mult_tab[k]) begin
      wr(SM, mult_tab[k]);
      rd(SM, mult_tab[k], "synth_multiplier");
      chk("taps", {6'h00, mult_tab[k][7:6]}, prescale_taps_o);
      chk("modulus", {2'h0, mult_tab[k][5:0]}, loop_modulus_o);
    end
    wr(PC, 8'ha8);
    settle(2);
    chk("run", 8'h01, synth_run_o);
    chk("bus src", 8'h00, bus_src_vco_o);
    settle(SETTLE_CYCLES);
    wr(PC, 8'he8);
    settle(2);
    chk("bus src", 8'h01, bus_src_vco_o);
    // manual bandwidth, changes spaced by the settle time; the bit is judged
    // against the stored self-select, so leaving self mode takes its own write
    wr(PC, 8'hc8);
    settle(SETTLE_CYCLES);
    wr(PC, 8'hd8);
    rd(PC, 8'hda, "manual bw");
    chk("high drive", 8'h01, high_bw_drive_o);
    chk("low drive", 8'h01, low_bw_drive_o);
    settle(SETTLE_CYCLES);
    wr(PC, 8'hc8);
    rd(PC, 8'hca, "manual bw");
    chk("high drive", 8'h00, high_bw_drive_o);
    // filter test bit: writable only in test mode, forced in self mode
    wr(PC, 8'hc0);
    rd(PC, 8'hca, "filter locked");
    @(posedge core_clk_i) test_mode_i <= 1'b1;
    wr(PC, 8'hc0);
    rd(PC, 8'hc2, "filter test");
    chk("filter test", 8'h00, filter_test_o);
    wr(PC, 8'he0);
    rd(PC, 8'hea, "filter forced");
    chk("filter test", 8'h01, filter_test_o);
    @(posedge core_clk_i) test_mode_i <= 1'b0;
    // module clock source
    wr(PC, 8'he4);
    settle(2);
    chk("module src", 8'h01, module_src_quad_o);
    wr(PC, 8'he0);
    settle(2);
    chk("module src", 8'h00, module_src_quad_o);
    // wait slowdown, then wake by receiver, interrupt and reset
    wr(PC, 8'he1);
    pulse_wait;
    rd(PC, 8'hab, "wait entry");
    chk("idle", 8'h01, synth_idle_o);
    chk("bus src", 8'h00, bus_src_vco_o);
    chk("modulus", 8'h00, loop_modulus_o);
    @(posedge core_clk_i) receiver_active_flag_i <= 3'h7;
    settle(3);
    chk("idle", 8'h01, synth_idle_o);
    @(posedge core_clk_i) receiver_enable_bit_i <= 3'h2;
    settle(3);
    chk("idle", 8'h00, synth_idle_o);
    chk("modulus", 8'h05, loop_modulus_o);
    chk("bus src", 8'h00, bus_src_vco_o);
    @(posedge core_clk_i) receiver_active_flag_i <= 3'h0;
    settle(SETTLE_CYCLES);
    wr(PC, 8'he1);
    settle(2);
    chk("bus src", 8'h01, bus_src_vco_o);
    pulse_wait;
    chk("idle", 8'h01, synth_idle_o);
    @(posedge core_clk_i) irq_i <= 1'b1;
    @(posedge core_clk_i) irq_i <= 1'b0;
    settle(2);
    chk("idle", 8'h00, synth_idle_o);
    wr(PC, 8'he0);
    pulse_wait;
    chk("idle", 8'h00, synth_idle_o);
    chk("bus src", 8'h01, bus_src_vco_o);
    wr(PC, 8'he1);
    pulse_wait;
    chk("idle", 8'h01, synth_idle_o);
    @(posedge core_clk_i) lock_raw_i <= 1'b0;
    do_reset;
    check_defaults;
    give_verdict;
  end
endmodule
